// *** verilog/reset_timeout_sequencer.sv ***
// Reset and start-up sequencer: classifies reset causes, times the power-up and
// oscillator settle delays and keeps the reset cause flags, with an APB register port.
// Assumes supply monitors, reset pin, RC and main oscillator arrive asynchronously;
// watchdog timeout and sleeping status come from logic on clk.
//
// Added by the designer: the register offsets and the APB register port.
`include "reset_timeout_sequencer_regs.svh"

// Function
// - Tell apart six distinct reset causes
// - Keep-class register survives every reset, power-on included
// - Reset-class registers load except on watchdog wake
// - Filter ignores short low pin pulses
// - Watchdog reset never drives the pin
// - Power-on holds reset for 72 ms delay
// - Config bit enables or skips power-up delay
// - Settle count 1024 oscillator cycles after delay
// - Settle only crystal modes, power-on or wake
// - Brown-out after supply low exceeds 100 us
// - Brown-out holds until supply ok, then delay
// - Supply dip during delay restarts brown-out recovery
// - Brown-out enable forces power-up delay on
// - Power-up: delay, settle, then release reset
// - Held pin releases execution immediately on rise
// - Expiry and sleep flags follow reset cause
// - Supply-rise detector starts power-on sequence
// - Oscillator pin accepts resonator or driven clock
// - Two select bits encode oscillator mode
// - Power-on flag cleared only by power-on
module reset_timeout_sequencer #(
	parameter int PIN_FILTER_CYCLES = `RTS_PIN_FILTER_CYCLES,
	parameter int RC_KHZ = `RTS_RC_KHZ,
	parameter int PWRUP_RC_EDGES = `RTS_PWRUP_MS * RC_KHZ,
	parameter int BROWNOUT_QUAL_CYCLES = `RTS_BROWNOUT_QUAL_US * `RTS_CLK_MHZ,
	parameter int OSC_SETTLE_CYCLES = `RTS_OSC_SETTLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic supplyRiseDetect,
	input wire logic supplyLow,
	input wire logic externalResetPinN,
	input wire logic oscillatorInputPin,
	input wire logic rcOscClk,
	input wire logic watchdogTimeout,
	input wire logic cpuSleeping,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic coreHold,
	output logic loadResetState,
	output rts_pkg::cause_e resetCause,
	output logic watchdogExpiryFlag,
	output logic sleepEnteredFlag
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (PIN_FILTER_CYCLES < 1 || PIN_FILTER_CYCLES > 65535 || PWRUP_RC_EDGES < 1 ||
		PWRUP_RC_EDGES > 65535 || BROWNOUT_QUAL_CYCLES < 1 || BROWNOUT_QUAL_CYCLES > 65535 ||
		OSC_SETTLE_CYCLES < 1 || OSC_SETTLE_CYCLES > 65535) begin : g_bad_param
		$error("reset_timeout_sequencer: count parameter out of 1..65535");
	end

	localparam logic [15:0] PIN_LAST = 16'(PIN_FILTER_CYCLES - 1);
	localparam logic [15:0] PWRUP_LAST = 16'(PWRUP_RC_EDGES - 1);
	localparam logic [15:0] QUAL_LAST = 16'(BROWNOUT_QUAL_CYCLES - 1);
	localparam logic [15:0] SETTLE_LAST = 16'(OSC_SETTLE_CYCLES - 1);

	// Crystal or resonator modes are every code but RC
	function automatic logic isCrystal(input logic [1:0] sel);
		isCrystal = (sel != `RTS_OSC_RC);
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] pinSync_r;
	logic [1:0] supSync_r;
	logic [2:0] riseSync_r;
	logic [2:0] rcSync_r;
	logic [2:0] oscSync_r;

	// Async pins pass two flops; third stage feeds edge detection only
	// pin synchronised here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinSync_r <= 2'h3;
			supSync_r <= 2'h0;
			riseSync_r <= 3'h0;
			rcSync_r <= 3'h0;
			oscSync_r <= 3'h0;
		end else begin
			pinSync_r <= {pinSync_r[0], externalResetPinN};
			supSync_r <= {supSync_r[0], supplyLow};
			riseSync_r <= {riseSync_r[1:0], supplyRiseDetect};
			rcSync_r <= {rcSync_r[1:0], rcOscClk};
			oscSync_r <= {oscSync_r[1:0], oscillatorInputPin};
		end
	end

	logic pinHigh;
	logic supLow;
	logic porEvent;
	logic rcEdge;
	logic oscEdge;
	assign pinHigh = pinSync_r[1];
	assign supLow = supSync_r[1];
	assign porEvent = riseSync_r[1] & ~riseSync_r[2];
	assign rcEdge = rcSync_r[1] & ~rcSync_r[2];
	assign oscEdge = oscSync_r[1] & ~oscSync_r[2];

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	logic [3:0] config_r;
	logic brownoutEnableBit;
	logic pwrupEnable;
	logic [1:0] oscillatorSelectBits;
	assign brownoutEnableBit = config_r[`RTS_CFG_BROWNOUT_EN];
	assign pwrupEnable = config_r[`RTS_CFG_PWRUP_EN];
	assign oscillatorSelectBits = config_r[`RTS_CFG_OSC_HI:`RTS_CFG_OSC_LO];

	// ----------------------------------------
	// Reset pin filter
	// ----------------------------------------
	logic [15:0] pinLowCnt_r;
	logic pinLow_r;
	logic pinLowDly_r;

	// A low must last the whole filter length; any high restarts it
	// glitch filter on pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinLowCnt_r <= 16'h0000;
			pinLow_r <= 1'b0;
			pinLowDly_r <= 1'b0;
		end else begin
			pinLowDly_r <= pinLow_r;
			if (pinHigh) begin
				pinLowCnt_r <= 16'h0000;
				pinLow_r <= 1'b0;
			end else if (pinLowCnt_r == PIN_LAST) begin
				pinLow_r <= 1'b1;
			end else begin
				pinLowCnt_r <= pinLowCnt_r + 16'h0001;
			end
		end
	end

	logic pinFall;
	assign pinFall = pinLow_r & ~pinLowDly_r;

	// ----------------------------------------
	// Brown-out qualification
	// ----------------------------------------
	logic [15:0] qualCnt_r;
	logic borEvent;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			qualCnt_r <= 16'h0000;
		end else if (!(brownoutEnableBit && supLow)) begin
			qualCnt_r <= 16'h0000;
		end else if (qualCnt_r != QUAL_LAST) begin
			qualCnt_r <= qualCnt_r + 16'h0001;
		end
	end
	// Fires once when the count first reaches one below its end value
	assign borEvent = brownoutEnableBit & supLow & (qualCnt_r == QUAL_LAST - 16'h0001);

	// ----------------------------------------
	// Event classification
	// ----------------------------------------
	rts_pkg::state_e state_r;
	rts_pkg::state_e stateNxt;
	logic evValid;
	rts_pkg::cause_e evCause;

	// Priority: power-on, brown-out, pin, watchdog
	// six cause classification
	always_comb begin
		evValid = 1'b1;
		evCause = rts_pkg::C_POWER_ON;
		if (porEvent || state_r == rts_pkg::S_START) begin
			evCause = rts_pkg::C_POWER_ON;
		end else if (borEvent) begin
			evCause = rts_pkg::C_BROWNOUT;
		end else if (pinFall && state_r == rts_pkg::S_RUN) begin
			evCause = cpuSleeping ? rts_pkg::C_PIN_SLEEP : rts_pkg::C_PIN_RUN;
		end else if (watchdogTimeout && state_r == rts_pkg::S_RUN) begin
			evCause = cpuSleeping ? rts_pkg::C_WATCHDOG_WAKE : rts_pkg::C_WATCHDOG_RUN;
		end else begin
			evValid = 1'b0;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic [15:0] cnt_r;
	logic crystal;
	logic delayOn;
	assign crystal = isCrystal(oscillatorSelectBits);
	assign delayOn = pwrupEnable | brownoutEnableBit;

	always_comb begin
		stateNxt = state_r;
		if (evValid) begin
			case (evCause)
				rts_pkg::C_POWER_ON: begin
					if (delayOn) begin
						stateNxt = rts_pkg::S_PWRUP_DELAY;
					end else if (crystal) begin
						stateNxt = rts_pkg::S_OSC_SETTLE;
					end else begin
						stateNxt = rts_pkg::S_WAIT_PIN;
					end
				end
				rts_pkg::C_BROWNOUT: stateNxt = rts_pkg::S_BROWNOUT_HOLD;
				rts_pkg::C_WATCHDOG_WAKE: begin
					stateNxt = crystal ? rts_pkg::S_OSC_SETTLE : rts_pkg::S_WAIT_PIN;
				end
				default: stateNxt = rts_pkg::S_WAIT_PIN;
			endcase
		end else begin
			case (state_r)
				rts_pkg::S_BROWNOUT_HOLD: begin
					if (!supLow) begin
						stateNxt = rts_pkg::S_PWRUP_DELAY;
					end
				end
				rts_pkg::S_PWRUP_DELAY: begin
					if (resetCause == rts_pkg::C_BROWNOUT && supLow) begin
						stateNxt = rts_pkg::S_BROWNOUT_HOLD;
					end else if (rcEdge && cnt_r == PWRUP_LAST) begin
						if (crystal && resetCause == rts_pkg::C_POWER_ON) begin
							stateNxt = rts_pkg::S_OSC_SETTLE;
						end else begin
							stateNxt = rts_pkg::S_WAIT_PIN;
						end
					end
				end
				rts_pkg::S_OSC_SETTLE: begin
					if (oscEdge && cnt_r == SETTLE_LAST) begin
						stateNxt = rts_pkg::S_WAIT_PIN;
					end
				end
				// run as soon as pin rises
				rts_pkg::S_WAIT_PIN: begin
					if (!pinLow_r) begin
						stateNxt = rts_pkg::S_RUN;
					end
				end
				default: stateNxt = state_r;
			endcase
		end
	end

	// State and shared delay counter; counter restarts on every state change
	// RC edge counting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= rts_pkg::S_START;
			cnt_r <= 16'h0000;
		end else begin
			state_r <= stateNxt;
			if (stateNxt != state_r || evValid) begin
				cnt_r <= 16'h0000;
			end else if ((state_r == rts_pkg::S_PWRUP_DELAY && rcEdge) ||
				(state_r == rts_pkg::S_OSC_SETTLE && oscEdge)) begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// Core hold and reset-class load pulse
	// wake skips register load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coreHold <= 1'b1;
			loadResetState <= 1'b0;
			resetCause <= rts_pkg::C_POWER_ON;
		end else begin
			coreHold <= (stateNxt != rts_pkg::S_RUN);
			loadResetState <= evValid && evCause != rts_pkg::C_WATCHDOG_WAKE;
			if (evValid) begin
				resetCause <= evCause;
			end
		end
	end

	// ----------------------------------------
	// Cause flags
	// ----------------------------------------
	logic powerOnFlag_r;
	logic brownoutFlag_r;
	logic apbWrite;
	assign apbWrite = psel & penable & pready & pwrite;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			watchdogExpiryFlag <= 1'b1;
			sleepEnteredFlag <= 1'b1;
		end else if (evValid) begin
			case (evCause)
				rts_pkg::C_POWER_ON, rts_pkg::C_BROWNOUT: begin
					watchdogExpiryFlag <= 1'b1;
					sleepEnteredFlag <= 1'b1;
				end
				rts_pkg::C_PIN_SLEEP: begin
					watchdogExpiryFlag <= 1'b1;
					sleepEnteredFlag <= 1'b0;
				end
				rts_pkg::C_WATCHDOG_RUN: begin
					watchdogExpiryFlag <= 1'b0;
					sleepEnteredFlag <= 1'b1;
				end
				rts_pkg::C_WATCHDOG_WAKE: begin
					watchdogExpiryFlag <= 1'b0;
					sleepEnteredFlag <= 1'b0;
				end
				default: begin
					watchdogExpiryFlag <= watchdogExpiryFlag;
					sleepEnteredFlag <= sleepEnteredFlag;
				end
			endcase
		end
	end

	// Hardware clear beats a software set in the same cycle
	// power-on flag cleared only here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			powerOnFlag_r <= 1'b0;
			brownoutFlag_r <= 1'b0;
		end else begin
			if (evValid && evCause == rts_pkg::C_POWER_ON) begin
				powerOnFlag_r <= 1'b0;
			end else if (apbWrite && paddr == `RTS_OFF_STATUS && pwdata[`RTS_ST_POWER_ON]) begin
				powerOnFlag_r <= 1'b1;
			end
			if (evValid && evCause == rts_pkg::C_BROWNOUT) begin
				brownoutFlag_r <= 1'b0;
			end else if (apbWrite && paddr == `RTS_OFF_STATUS && pwdata[`RTS_ST_BROWNOUT]) begin
				brownoutFlag_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic [31:0] general_r;
	logic [31:0] keep_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			config_r <= `RTS_CFG_RESET;
		end else if (apbWrite && paddr == `RTS_OFF_CONFIG) begin
			config_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			general_r <= `RTS_GENERAL_RESET;
		end else if (evValid && evCause != rts_pkg::C_WATCHDOG_WAKE) begin
			general_r <= `RTS_GENERAL_RESET;
		end else if (apbWrite && paddr == `RTS_OFF_GENERAL) begin
			general_r <= pwdata;
		end
	end

	// No reset at all: unknown at power-up, kept through every later reset
	// keep-class register
	always_ff @(posedge clk) begin
		if (apbWrite && paddr == `RTS_OFF_KEEP) begin
			keep_r <= pwdata;
		end
	end

	// ----------------------------------------
	// APB slave: one wait state, registered answer
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			case (paddr)
				`RTS_OFF_CONFIG: prdata <= {28'h0000000, config_r};
				`RTS_OFF_STATUS: prdata <= {25'h0000000, resetCause, brownoutFlag_r,
					powerOnFlag_r, sleepEnteredFlag, watchdogExpiryFlag};
				`RTS_OFF_GENERAL: prdata <= general_r;
				`RTS_OFF_KEEP: prdata <= keep_r;
				default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

// *** include/reset_timeout_sequencer_regs.svh ***
// Register offsets, field positions, reset values and timing figures of the sequencer.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit address bus.
`ifndef RESET_TIMEOUT_SEQUENCER_REGS_SVH
`define RESET_TIMEOUT_SEQUENCER_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTS_OFF_CONFIG 8'h00
`define RTS_OFF_STATUS 8'h04
`define RTS_OFF_GENERAL 8'h08
`define RTS_OFF_KEEP 8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTS_CFG_BROWNOUT_EN 0
`define RTS_CFG_PWRUP_EN 1
`define RTS_CFG_OSC_LO 2
`define RTS_CFG_OSC_HI 3
`define RTS_ST_WDOG_EXPIRY 0
`define RTS_ST_SLEEP_ENTERED 1
`define RTS_ST_POWER_ON 2
`define RTS_ST_BROWNOUT 3
`define RTS_ST_CAUSE_LO 4
`define RTS_ST_CAUSE_HI 6

// ----------------------------------------
// Reset values and oscillator codes
// ----------------------------------------
`define RTS_CFG_RESET 4'hd
`define RTS_GENERAL_RESET 32'h00000000
`define RTS_OSC_RC 2'h3
`define RTS_OSC_HIGH_SPEED 2'h2
`define RTS_OSC_STANDARD 2'h1
`define RTS_OSC_LOW_POWER 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTS_CLK_MHZ 100
`define RTS_PWRUP_MS 72
`define RTS_RC_KHZ 100
`define RTS_OSC_SETTLE_CYCLES 1024
`define RTS_BROWNOUT_QUAL_US 100
`define RTS_PIN_FILTER_CYCLES 16

`endif

// *** include/rts_pkg.sv ***
// Types shared by the reset sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package rts_pkg;

	// ----------------------------------------
	// Sequencer states and reset causes
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_START,
		S_BROWNOUT_HOLD,
		S_PWRUP_DELAY,
		S_OSC_SETTLE,
		S_WAIT_PIN,
		S_RUN
	} state_e;

	typedef enum logic [2:0] {
		C_POWER_ON,
		C_PIN_RUN,
		C_PIN_SLEEP,
		C_WATCHDOG_RUN,
		C_WATCHDOG_WAKE,
		C_BROWNOUT
	} cause_e;

endpackage

// *** verif/rts_props.sv ***
// Checker for the reset sequencer, bound to its top module.
// Assumes single clock clk and asynchronous active-high rst.
module rts_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic supplyRiseDetect,
	input wire logic supplyLow,
	input wire logic externalResetPinN,
	input wire logic watchdogTimeout,
	input wire logic cpuSleeping,
	input wire logic coreHold,
	input wire logic loadResetState,
	input rts_pkg::cause_e resetCause,
	input wire logic watchdogExpiryFlag,
	input wire logic sleepEnteredFlag
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Run-time watchdog resets internally; with the pin high the core is released within three cycles
	wdog_run_reset_a: assert property (
		watchdogTimeout && !coreHold && !cpuSleeping && externalResetPinN && !supplyLow
		|=> loadResetState && coreHold && resetCause == rts_pkg::C_WATCHDOG_RUN
		&& !watchdogExpiryFlag && sleepEnteredFlag ##[1:3] !coreHold)
		else $error("watchdog run reset wrong");
	wdog_wake_a: assert property (
		watchdogTimeout && !coreHold && cpuSleeping && externalResetPinN && !supplyLow
		|=> !loadResetState && resetCause == rts_pkg::C_WATCHDOG_WAKE
		&& !watchdogExpiryFlag && !sleepEnteredFlag)
		else $error("watchdog wake wrong");
	load_pulse_a: assert property (
		loadResetState |-> coreHold ##1 !loadResetState)
		else $error("register load pulse wrong");
	// Two-cycle low is shorter than the filter
	pin_glitch_a: assert property (
		$fell(externalResetPinN) && !coreHold ##1 !externalResetPinN ##1 externalResetPinN
		|-> !loadResetState [*8])
		else $error("short pin pulse caused reset");
	pin_hold_a: assert property (
		!externalResetPinN && !$past(externalResetPinN) && coreHold |=> coreHold)
		else $error("core released while pin low");
	supply_hold_a: assert property (
		supplyLow && coreHold |=> coreHold)
		else $error("core released while supply low");
	supply_dip_a: assert property (
		$rose(supplyLow) && !coreHold ##1 supplyLow [*2] ##1 !supplyLow
		|-> !loadResetState [*8])
		else $error("short supply dip caused reset");
	power_on_a: assert property (
		$rose(supplyRiseDetect)
		|-> ##[1:8] (loadResetState && resetCause == rts_pkg::C_POWER_ON))
		else $error("power-on event not taken");
endmodule

bind reset_timeout_sequencer rts_props rts_props_i (
	.clk(clk), .rst(rst), .supplyRiseDetect(supplyRiseDetect), .supplyLow(supplyLow),
	.externalResetPinN(externalResetPinN), .watchdogTimeout(watchdogTimeout),
	.cpuSleeping(cpuSleeping), .coreHold(coreHold), .loadResetState(loadResetState),
	.resetCause(resetCause), .watchdogExpiryFlag(watchdogExpiryFlag),
	.sleepEnteredFlag(sleepEnteredFlag)
);

// *** verif/rts_partner.sv ***
// Far-side model: free-running main oscillator and internal RC oscillator.
// Assumes clk is the sequencer clock; outputs change just after its rising edge.
module rts_partner #(
	parameter int OSC_HALF = 2,
	parameter int RC_HALF = 3
) (
	input wire logic clk,
	output logic oscillatorInputPin,
	output logic rcOscClk
);
	timeunit 1ns;
	timeprecision 1ns;
	int oscCnt = 0;
	int rcCnt = 0;

	initial begin
		oscillatorInputPin = 1'b0;
		rcOscClk = 1'b0;
	end

	// driven clock input
	// A driven square wave stands in for a resonator; it runs free as a real one would
	always @(posedge clk) begin
		oscCnt <= (oscCnt == OSC_HALF - 1) ? 0 : oscCnt + 1;
		if (oscCnt == OSC_HALF - 1) oscillatorInputPin <= !oscillatorInputPin;
	end

	// Slower RC clock, period 6 clk against 4 clk for the main oscillator
	always @(posedge clk) begin
		rcCnt <= (rcCnt == RC_HALF - 1) ? 0 : rcCnt + 1;
		if (rcCnt == RC_HALF - 1) rcOscClk <= !rcOscClk;
	end
endmodule

// *** verif/reset_timeout_sequencer_bench.sv ***
// Bench for the reset sequencer: APB tasks and reset-event sequences.
// Assumes the partner makes both oscillators; long counts are cut to 8 by parameters.
`include "reset_timeout_sequencer_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, 32'(g), 32'(e)); end end
module reset_timeout_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, supplyRiseDetect = 0, supplyLow = 0, externalResetPinN = 1;
	logic watchdogTimeout = 0, cpuSleeping = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, coreHold, loadResetState, watchdogExpiryFlag, sleepEnteredFlag;
	logic rcOscClk, oscillatorInputPin, e;
	rts_pkg::cause_e resetCause;
	int error_cnt = 0, n_checks = 0, n;
	// Bit 4: power-on event (else watchdog wake); expected hold with RC 6, osc 4 clk
	logic [4:0] tcfg [8] = '{5'h1c, 5'h12, 5'h10, 5'h11, 5'h0d, 5'h09, 5'h05, 5'h01};
	int texp [8] = '{0, 80, 32, 80, 0, 32, 32, 32};

	initial begin
		forever #5 clk = !clk;
	end

	reset_timeout_sequencer #(.PIN_FILTER_CYCLES(4), .PWRUP_RC_EDGES(8),
		.BROWNOUT_QUAL_CYCLES(8), .OSC_SETTLE_CYCLES(8)) reset_timeout_sequencer_i (
		.clk(clk), .rst(rst), .supplyRiseDetect(supplyRiseDetect), .supplyLow(supplyLow),
		.externalResetPinN(externalResetPinN), .oscillatorInputPin(oscillatorInputPin),
		.rcOscClk(rcOscClk), .watchdogTimeout(watchdogTimeout), .cpuSleeping(cpuSleeping),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .coreHold(coreHold),
		.loadResetState(loadResetState), .resetCause(resetCause),
		.watchdogExpiryFlag(watchdogExpiryFlag), .sleepEnteredFlag(sleepEnteredFlag));
	rts_partner rts_partner_i (.clk(clk), .oscillatorInputPin(oscillatorInputPin),
		.rcOscClk(rcOscClk));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Ready and data are taken at the rising edge that sees pready; release follows it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
			if (i == 20) begin
				error_cnt++;
				give_verdict();
			end
		end
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// Drive one event line: 0 supply rise, 1 supply low, 2 pin low, 3 watchdog
	task automatic drive(input int s, input logic v);
		case (s)
			0: supplyRiseDetect <= v;
			1: supplyLow <= v;
			2: externalResetPinN <= !v;
			default: watchdogTimeout <= v;
		endcase
	endtask

	task automatic pulse(input int s, input int len);
		@(posedge clk);
		drive(s, 1'b1);
		repeat (len) @(posedge clk);
		drive(s, 1'b0);
	endtask

	// Count held cycles; gives up early when the core is never held
	task automatic hold_len();
		n = 0;
		for (int i = 0; i < 3000; i++) begin
			#1;
			if (coreHold === 1'b1) n++;
			else if (n > 0 || i > 10) return;
			@(posedge clk);
		end
		error_cnt++;
		give_verdict();
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		hold_len();
		`CHK(n >= 44 && n <= 60, 1'b1)
		apb(1'b0, `RTS_OFF_CONFIG, 32'h0);
		`CHK(q, 32'h0000000d)
		apb(1'b0, `RTS_OFF_STATUS, 32'h0);
		`CHK(q & 32'h7f, 32'h03)
		apb(1'b0, 8'h10, 32'h0);
		`CHK({e, q}, 33'h100000000)
		apb(1'b1, `RTS_OFF_KEEP, 32'ha5);
		done("reset");
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, `RTS_OFF_CONFIG, 32'(tcfg[k][3:0]));
			apb(1'b1, `RTS_OFF_GENERAL, 32'h5a);
			apb(1'b1, `RTS_OFF_STATUS, 32'h0c);
			cpuSleeping <= !tcfg[k][4];
			pulse(tcfg[k][4] ? 0 : 3, tcfg[k][4] ? 3 : 1);
			hold_len();
			cpuSleeping <= 1'b0;
			`CHK(n >= (texp[k] > 4 ? texp[k] - 4 : 0) && n <= texp[k] + 12, 1'b1)
			apb(1'b0, `RTS_OFF_GENERAL, 32'h0);
			`CHK(q, tcfg[k][4] ? 32'h0 : 32'h5a)
			apb(1'b0, `RTS_OFF_KEEP, 32'h0);
			`CHK(q, 32'ha5)
			apb(1'b0, `RTS_OFF_STATUS, 32'h0);
			`CHK(q & 32'h77, tcfg[k][4] ? 32'h03 : 32'h44)
		end
		done("modes");
		apb(1'b1, `RTS_OFF_GENERAL, 32'h5a);
		pulse(3, 1);
		hold_len();
		`CHK(n >= 1 && n <= 3, 1'b1)
		apb(1'b0, `RTS_OFF_STATUS, 32'h0);
		`CHK(q & 32'h7f, 32'h3e)
		apb(1'b0, `RTS_OFF_GENERAL, 32'h0);
		`CHK(q, 32'h0)
		pulse(2, 12);
		#1 `CHK(coreHold, 1'b1)
		hold_len();
		`CHK(n >= 1 && n <= 6, 1'b1)
		pulse(2, 2);
		repeat (10) @(posedge clk);
		apb(1'b0, `RTS_OFF_STATUS, 32'h0);
		`CHK(q & 32'h7f, 32'h1e)
		cpuSleeping <= 1'b1;
		pulse(2, 8);
		hold_len();
		cpuSleeping <= 1'b0;
		apb(1'b0, `RTS_OFF_STATUS, 32'h0);
		`CHK(q & 32'h7f, 32'h2d)
		done("pin watchdog");
		apb(1'b1, `RTS_OFF_GENERAL, 32'h5a);
		pulse(1, 20);
		#1 `CHK(coreHold, 1'b1)
		repeat (20) @(posedge clk);
		pulse(1, 12);
		hold_len();
		`CHK(n >= 44 && n <= 64, 1'b1)
		apb(1'b0, `RTS_OFF_STATUS, 32'h0);
		`CHK(q & 32'h7f, 32'h57)
		apb(1'b0, `RTS_OFF_GENERAL, 32'h0);
		`CHK(q, 32'h0)
		pulse(1, 3);
		repeat (10) @(posedge clk);
		#1 `CHK(coreHold, 1'b0)
		done("brown-out");
		give_verdict();
	end
endmodule
